// File: ilp_params.svh
`ifndef ILP_PARAMS_SVH
`define ILP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Line and sample geometry
// ----------------------------------------------------------------------------
`define ILP_NUM_LINES      13
`define ILP_NUM_DIRECT     8
`define ILP_MASK_W         16
`define ILP_ADDR_W         16
`define ILP_AMASK_W        8
`define ILP_DUTY_W         10
`define ILP_TMO_W          8
`define ILP_PERIPH_W       4
`define ILP_SPI_W          4
`define ILP_CTS_BIT        0

// ----------------------------------------------------------------------------
// Line configuration codes and setting values
// ----------------------------------------------------------------------------
`define ILP_CODE_W         3
`define ILP_CODE_INPUT     3'h3
`define ILP_CODE_OUT_LOW   3'h4
`define ILP_CODE_OUT_HIGH  3'h5
`define ILP_SLEEP_W        3
`define ILP_SLEEP_OFF      3'h0
`define ILP_FWD_OFF        1'h0
`define ILP_BROADCAST      16'hFFFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ILP_CLK_PERIOD_NS  10
`define ILP_TMO_UNIT_MS    100
`define ILP_TICK_W         24
`define ILP_TICK_CYCLES    ((`ILP_TMO_UNIT_MS * 1000000) / `ILP_CLK_PERIOD_NS)

`endif

// File: ilp_pass.sv
// Contract
// - A remote input drives only the same-numbered output (4 or 5).
// - Each passable line has its own timeout; expiry returns it to its direct level, else config.
// - Only D and P group lines pass; UART and SPI pins never do.
// - Only samples from the filter address change outputs.
// - Filter value 0xFFFF accepts samples from every source.
// - Outputs update the same way in framed and transparent host mode.
// - Framed mode forwards samples unless forwarding is off for matches.
// - Non-matching samples are always forwarded in framed mode.
// - Remote ADC 0 and 1 drive local duty outputs 0 and 1.
// - One shared analog timeout returns both duty outputs to presets.
// - Direct level command sets lines 0-7 persistently, no timeout.
// - A direct level change requests a change-detect sample.
// - While asleep, output lines hold; others follow pull settings.
// - Asleep: peripheral pins low except clear-to-send, SPI pins high.
// - Passed levels hold in sleep; their timers pause and resume.
// - Duty outputs are low while asleep and resume on wake.
// - On wake, passed duty outputs revert to presets regardless of timer.
// - Sample carries a 16-bit digital mask and matching data word.
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_pass #(
  parameter logic [`ILP_TICK_W-1:0] TICK_CYCLES =
    `ILP_TICK_W'(`ILP_TICK_CYCLES)
) (
  // Clock and reset.
  input  wire logic                                 CLK_SYS,
  input  wire logic                                 RST_N,
  // Received sample transaction.
  input  wire logic                                 SAMPLE_VALID,
  input  wire logic [`ILP_ADDR_W-1:0]               SAMPLE_SOURCE,
  input  wire logic [`ILP_MASK_W-1:0]               SAMPLE_DIGITAL_MASK,
  input  wire logic [`ILP_MASK_W-1:0]               SAMPLE_DIGITAL_DATA,
  input  wire logic [`ILP_AMASK_W-1:0]              SAMPLE_ANALOG_MASK,
  input  ilp_pkg::ilp_duty_t                        SAMPLE_ANALOG_ZERO,
  input  ilp_pkg::ilp_duty_t                        SAMPLE_ANALOG_ONE,
  // Host interface configuration.
  input  wire logic                                 API_MODE,
  input  wire logic                                 SERIAL_SAMPLE_FORWARD,
  input  wire logic [`ILP_ADDR_W-1:0]               SOURCE_FILTER_ADDRESS,
  // Digital line configuration.
  input  wire logic [`ILP_NUM_LINES*`ILP_CODE_W-1:0] LINE_CONFIG,
  input  wire logic [`ILP_NUM_LINES*`ILP_TMO_W-1:0]  DIGITAL_TIMEOUTS,
  input  wire logic [`ILP_NUM_LINES-1:0]            PULL_UP_ENABLES,
  input  wire logic [`ILP_NUM_LINES-1:0]            PULL_DIRECTION,
  // Duty output configuration.
  input  wire logic [1:0]                           DUTY_ENABLE,
  input  ilp_pkg::ilp_duty_t                        DUTY_PRESET_ZERO,
  input  ilp_pkg::ilp_duty_t                        DUTY_PRESET_ONE,
  input  wire logic [`ILP_TMO_W-1:0]                ANALOG_PASS_TIMEOUT,
  // Direct level command.
  input  wire logic                                 LEVEL_WRITE,
  input  wire logic [`ILP_NUM_DIRECT-1:0]           LEVEL_VALUES,
  // Sleep control.
  input  wire logic [`ILP_SLEEP_W-1:0]              SLEEP_SELECT,
  input  wire logic                                 SLEEP_ACTIVE,
  // Peripheral pin sources in normal operation.
  input  wire logic [`ILP_PERIPH_W-1:0]             PERIPH_NORMAL,
  input  wire logic [`ILP_SPI_W-1:0]                SPI_NORMAL,
  // Digital line pins.
  output logic [`ILP_NUM_LINES-1:0]                 LINE_OUT,
  output logic [`ILP_NUM_LINES-1:0]                 LINE_OE_N,
  output logic [`ILP_NUM_LINES-1:0]                 LINE_PULL_EN,
  output logic [`ILP_NUM_LINES-1:0]                 LINE_PULL_UP,
  // Duty output levels.
  output ilp_pkg::ilp_duty_t                        DUTY_OUTPUT_ZERO,
  output ilp_pkg::ilp_duty_t                        DUTY_OUTPUT_ONE,
  // Peripheral pins.
  output logic [`ILP_PERIPH_W-1:0]                  PERIPH_OUT,
  output logic [`ILP_SPI_W-1:0]                     SPI_OUT,
  // Serial and sampling requests.
  output logic                                      FRAME_EMIT,
  output logic                                      CHANGE_SAMPLE_REQ
);
  import ilp_pkg::*;

  localparam int NL = `ILP_NUM_LINES;
  localparam int ND = `ILP_NUM_DIRECT;
  localparam logic [`ILP_PERIPH_W-1:0] CTS_KEEP =
    `ILP_PERIPH_W'(1) << `ILP_CTS_BIT;
  localparam logic [NL-1:0] DIRECT_LINES = NL'({ND{1'b1}});

  // --------------------------------------------------------------------------
  // Reset release and shared decode
  // --------------------------------------------------------------------------
  logic            rst_n;
  logic            match;
  logic            accept;
  logic            asleep;
  logic            wake;
  logic            a_start;
  logic            a_expire;
  logic [NL-1:0]   is_out;
  logic [NL-1:0]   cfg_high;
  logic [NL-1:0]   d_start;
  logic [NL-1:0]   d_expire;

  ilp_state_t s;
  ilp_state_t n;

  ilp_rst_sync u_rst (
    .clk       (CLK_SYS),
    .rst_in_n  (RST_N),
    .rst_out_n (rst_n)
  );

  // Filter and sleep qualifiers; host mode takes no part in acceptance.
  assign match  = (SOURCE_FILTER_ADDRESS == `ILP_BROADCAST) ||
                  (SAMPLE_SOURCE == SOURCE_FILTER_ADDRESS);
  assign accept = SAMPLE_VALID && match;
  assign asleep = SLEEP_ACTIVE && (SLEEP_SELECT != `ILP_SLEEP_OFF);
  assign wake   = s.asleep_d && !asleep;

  // Analog restart when either enabled duty output takes a new value.
  assign a_start = accept &&
                   ((SAMPLE_ANALOG_MASK[0] && DUTY_ENABLE[0]) ||
                    (SAMPLE_ANALOG_MASK[1] && DUTY_ENABLE[1]));

  // --------------------------------------------------------------------------
  // Per-line decode and timers
  // --------------------------------------------------------------------------
  // Mask bits above the last passable line belong to UART and SPI pins and
  // are simply never looked at.
  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : g_line
      logic [`ILP_CODE_W-1:0] code;
      assign code = LINE_CONFIG[g*`ILP_CODE_W +: `ILP_CODE_W];
      assign is_out[g]   = (code == `ILP_CODE_OUT_LOW) ||
                           (code == `ILP_CODE_OUT_HIGH);
      assign cfg_high[g] = (code == `ILP_CODE_OUT_HIGH);
      assign d_start[g]  = accept && SAMPLE_DIGITAL_MASK[g] &&
                           is_out[g];
      ilp_timeout u_tmo (
        .clk     (CLK_SYS),
        .rst_n   (rst_n),
        .start   (d_start[g]),
        .setting (DIGITAL_TIMEOUTS[g*`ILP_TMO_W +: `ILP_TMO_W]),
        .tick    (s.tick),
        .expire  (d_expire[g])
      );
    end
  endgenerate

  // The two duty outputs share one timer, so a sample for either restarts
  // the hold of both.
  ilp_timeout u_tmo_analog (
    .clk     (CLK_SYS),
    .rst_n   (rst_n),
    .start   (a_start),
    .setting (ANALOG_PASS_TIMEOUT),
    .tick    (s.tick),
    .expire  (a_expire)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [NL-1:0] ovr_act_x;
    logic [NL-1:0] ovr_lvl_x;
    ovr_act_x = '0;
    ovr_lvl_x = '0;
    n         = s;
    n.tick    = 1'b0;

    // Timeout prescaler stands still while asleep, which pauses every timer.
    if (!asleep) begin
      if (s.tick_cnt == TICK_CYCLES - 1'b1) begin
        n.tick_cnt = '0;
        n.tick     = 1'b1;
      end else begin
        n.tick_cnt = s.tick_cnt + 1'b1;
      end
    end
    n.asleep_d = asleep;

    // Expiry is applied before new samples so a sample in the same cycle
    // wins and its level is not lost.
    n.pass_act = s.pass_act & ~d_expire;
    for (int i = 0; i < NL; i++) begin
      if (d_start[i]) begin
        n.pass_act[i] = 1'b1;
        n.pass_lvl[i] = SAMPLE_DIGITAL_DATA[i];
      end
    end

    // Direct levels persist and cancel any pending passed level.
    if (LEVEL_WRITE) begin
      for (int i = 0; i < ND; i++) begin
        if (is_out[i]) begin
          n.ovr_act[i]  = 1'b1;
          n.ovr_lvl[i]  = LEVEL_VALUES[i];
          n.pass_act[i] = 1'b0;
        end
      end
    end

    // A line leaving output mode forgets both passed and direct levels.
    n.pass_act = n.pass_act & is_out;
    n.ovr_act  = n.ovr_act & is_out[ND-1:0];
    ovr_act_x  = NL'(n.ovr_act);
    ovr_lvl_x  = NL'(n.ovr_lvl);

    // Effective pin level: passed level, else direct level, else config.
    for (int i = 0; i < NL; i++) begin
      if (n.pass_act[i]) begin
        n.line_lvl[i] = n.pass_lvl[i];
      end else if (ovr_act_x[i]) begin
        n.line_lvl[i] = ovr_lvl_x[i];
      end else begin
        n.line_lvl[i] = cfg_high[i];
      end
    end
    n.line_oe_n = ~is_out;
    n.pull_en   = PULL_UP_ENABLES & ~is_out;
    n.pull_up   = PULL_DIRECTION;

    // Change-detect request only when the command really moved a level.
    n.change_req = LEVEL_WRITE &&
                   (|((n.line_lvl ^ s.line_lvl) & is_out &
                      DIRECT_LINES));

    // Duty outputs: expiry and wake revert, then new samples apply.
    if (a_expire) begin
      n.duty_pass = 2'b00;
    end
    if (wake) begin
      n.duty_pass = 2'b00;
    end
    if (accept && SAMPLE_ANALOG_MASK[0] && DUTY_ENABLE[0]) begin
      n.duty_pass[0] = 1'b1;
      n.duty0_val    = SAMPLE_ANALOG_ZERO;
    end
    if (accept && SAMPLE_ANALOG_MASK[1] && DUTY_ENABLE[1]) begin
      n.duty_pass[1] = 1'b1;
      n.duty1_val    = SAMPLE_ANALOG_ONE;
    end
    n.duty_pass = n.duty_pass & DUTY_ENABLE;
    if (asleep || !DUTY_ENABLE[0]) begin
      n.duty0_out = '0;
    end else begin
      n.duty0_out = n.duty_pass[0] ? n.duty0_val : DUTY_PRESET_ZERO;
    end
    if (asleep || !DUTY_ENABLE[1]) begin
      n.duty1_out = '0;
    end else begin
      n.duty1_out = n.duty_pass[1] ? n.duty1_val : DUTY_PRESET_ONE;
    end

    // Peripheral pins park at low-current levels while asleep.
    if (asleep) begin
      n.periph = PERIPH_NORMAL & CTS_KEEP;
      n.spi    = '1;
    end else begin
      n.periph = PERIPH_NORMAL;
      n.spi    = SPI_NORMAL;
    end

    // Matching samples may be withheld; foreign ones always go out in framed mode.
    n.frame_emit = SAMPLE_VALID && API_MODE &&
                   (!match ||
                    (SERIAL_SAMPLE_FORWARD != `ILP_FWD_OFF));
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.line_oe_n <= '1;
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign LINE_OUT          = s.line_lvl;
  assign LINE_OE_N         = s.line_oe_n;
  assign LINE_PULL_EN      = s.pull_en;
  assign LINE_PULL_UP      = s.pull_up;
  assign DUTY_OUTPUT_ZERO  = s.duty0_out;
  assign DUTY_OUTPUT_ONE   = s.duty1_out;
  assign PERIPH_OUT        = s.periph;
  assign SPI_OUT           = s.spi;
  assign FRAME_EMIT        = s.frame_emit;
  assign CHANGE_SAMPLE_REQ = s.change_req;
endmodule : ilp_pass

// File: ilp_pass_properties.sv
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_pass_properties (
  // Clock and reset.
  input  wire logic                                  CLK_SYS,
  input  wire logic                                  RST_N,
  // Sample and configuration inputs.
  input  wire logic                                  SAMPLE_VALID,
  input  wire logic [`ILP_ADDR_W-1:0]                SAMPLE_SOURCE,
  input  wire logic                                  API_MODE,
  input  wire logic                                  SERIAL_SAMPLE_FORWARD,
  input  wire logic [`ILP_ADDR_W-1:0]                SOURCE_FILTER_ADDRESS,
  input  wire logic [`ILP_NUM_LINES*`ILP_CODE_W-1:0] LINE_CONFIG,
  input  wire logic [`ILP_NUM_LINES-1:0]             PULL_UP_ENABLES,
  input  wire logic                                  LEVEL_WRITE,
  input  wire logic [`ILP_SLEEP_W-1:0]               SLEEP_SELECT,
  input  wire logic                                  SLEEP_ACTIVE,
  input  wire logic [`ILP_PERIPH_W-1:0]              PERIPH_NORMAL,
  input  wire logic [`ILP_SPI_W-1:0]                 SPI_NORMAL,
  // Observed outputs.
  input  wire logic [`ILP_NUM_LINES-1:0]             LINE_OE_N,
  input  wire logic [`ILP_NUM_LINES-1:0]             LINE_PULL_EN,
  input  ilp_pkg::ilp_duty_t                         DUTY_OUTPUT_ZERO,
  input  ilp_pkg::ilp_duty_t                         DUTY_OUTPUT_ONE,
  input  wire logic [`ILP_PERIPH_W-1:0]              PERIPH_OUT,
  input  wire logic [`ILP_SPI_W-1:0]                 SPI_OUT,
  input  wire logic                                  FRAME_EMIT,
  input  wire logic                                  CHANGE_SAMPLE_REQ
);
  import ilp_pkg::*;

  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  logic [`ILP_NUM_LINES-1:0] is_out;
  logic [1:0]                rdy;
  logic                      asleep;
  logic                      match;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // Output lines by code; outputs are held at reset values for two edges.
  for (genvar i = 0; i < `ILP_NUM_LINES; i++) begin : g_cfg
    assign is_out[i] = (LINE_CONFIG[3*i+:3] == `ILP_CODE_OUT_LOW) ||
                       (LINE_CONFIG[3*i+:3] == `ILP_CODE_OUT_HIGH);
  end
  assign asleep = SLEEP_ACTIVE && (SLEEP_SELECT != `ILP_SLEEP_OFF);
  assign match  = (SOURCE_FILTER_ADDRESS == `ILP_BROADCAST) ||
                  (SOURCE_FILTER_ADDRESS == SAMPLE_SOURCE);

  // Counts edges since release so checks skip the synchroniser delay.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdy <= 2'h0;
    end else if (rdy != 2'h3) begin
      rdy <= rdy + 2'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  AST_FRAME_DECISION: assert property (
    rdy == 2'h3 && SAMPLE_VALID |=>
    FRAME_EMIT == $past(API_MODE && (!match || SERIAL_SAMPLE_FORWARD)))
    else $error("Frame emit differs from forwarding decision.");
  AST_FRAME_PULSE: assert property (
    rdy == 2'h3 && !SAMPLE_VALID |=> !FRAME_EMIT)
    else $error("Frame emit without a sample.");
  AST_DUTY_SLEEP: assert property (
    rdy == 2'h3 && asleep |=> DUTY_OUTPUT_ZERO == '0 && DUTY_OUTPUT_ONE == '0)
    else $error("Duty outputs not low while asleep.");
  AST_SPI_SLEEP: assert property (
    rdy == 2'h3 && asleep |=> SPI_OUT == 4'hF)
    else $error("Serial bus pins not high while asleep.");
  AST_PERIPH_SLEEP: assert property (
    rdy == 2'h3 && asleep |=> PERIPH_OUT == ($past(PERIPH_NORMAL) & 4'h1))
    else $error("Peripheral pins not low while asleep.");
  AST_SPI_WAKE: assert property (
    rdy == 2'h3 && !asleep |=> SPI_OUT == $past(SPI_NORMAL))
    else $error("Serial bus pins not normal while awake.");
  AST_LINE_DRIVE: assert property (
    rdy == 2'h3 |=> LINE_OE_N == ~$past(is_out))
    else $error("Line drive enable differs from line codes.");
  AST_PULL_ENABLE: assert property (
    rdy == 2'h3 |=> LINE_PULL_EN == $past(PULL_UP_ENABLES & ~is_out))
    else $error("Pull enable differs from settings.");
  AST_CHANGE_CAUSE: assert property (
    rdy == 2'h3 && CHANGE_SAMPLE_REQ |-> $past(LEVEL_WRITE))
    else $error("Change request without a level command.");
  COV_SLEEP: cover property (asleep ##1 !asleep);
endmodule : ilp_pass_properties

bind ilp_pass ilp_pass_properties u_props (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE_SOURCE(SAMPLE_SOURCE), .API_MODE(API_MODE),
  .SERIAL_SAMPLE_FORWARD(SERIAL_SAMPLE_FORWARD),
  .SOURCE_FILTER_ADDRESS(SOURCE_FILTER_ADDRESS), .LINE_CONFIG(LINE_CONFIG),
  .PULL_UP_ENABLES(PULL_UP_ENABLES), .LEVEL_WRITE(LEVEL_WRITE),
  .SLEEP_SELECT(SLEEP_SELECT), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .PERIPH_NORMAL(PERIPH_NORMAL), .SPI_NORMAL(SPI_NORMAL),
  .LINE_OE_N(LINE_OE_N), .LINE_PULL_EN(LINE_PULL_EN),
  .DUTY_OUTPUT_ZERO(DUTY_OUTPUT_ZERO), .DUTY_OUTPUT_ONE(DUTY_OUTPUT_ONE),
  .PERIPH_OUT(PERIPH_OUT), .SPI_OUT(SPI_OUT), .FRAME_EMIT(FRAME_EMIT),
  .CHANGE_SAMPLE_REQ(CHANGE_SAMPLE_REQ));

// File: ilp_pass_tb.sv
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_pass_tb;
  import ilp_pkg::*;

  // ---------------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------------
  localparam logic [`ILP_TICK_W-1:0] TICK = `ILP_TICK_W'(4);
  localparam logic [15:0]            SRC  = 16'h1234;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic s_valid, api = 1'b1, fwd = 1'b1, lw = 1'b0, sact = 1'b0;
  logic [15:0] s_src, s_dm, s_dd, filt = SRC;
  logic [7:0] s_am, lv = 8'h00;
  ilp_duty_t s_a0, s_a1, d0, d1;
  logic [38:0] cfg = {3'h3, {12{3'h4}}};
  logic [103:0] tmo = 104'h02_0000;
  logic [12:0] pue = 13'h1FFF, pdir = 13'h0F0F;
  logic [12:0] lo, loe, lpe, lpu;
  logic [2:0] ssel = 3'h0;
  logic [1:0] den = 2'h3;
  logic [3:0] po, so;
  logic fe, csr;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  ilp_remote_node rn (.clk(clk_sys), .valid(s_valid), .source(s_src),
    .dmask(s_dm), .ddata(s_dd), .amask(s_am), .a0(s_a0), .a1(s_a1));

  ilp_pass #(.TICK_CYCLES(TICK)) DUT (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SAMPLE_VALID(s_valid),
    .SAMPLE_SOURCE(s_src), .SAMPLE_DIGITAL_MASK(s_dm),
    .SAMPLE_DIGITAL_DATA(s_dd), .SAMPLE_ANALOG_MASK(s_am),
    .SAMPLE_ANALOG_ZERO(s_a0), .SAMPLE_ANALOG_ONE(s_a1), .API_MODE(api),
    .SERIAL_SAMPLE_FORWARD(fwd), .SOURCE_FILTER_ADDRESS(filt),
    .LINE_CONFIG(cfg), .DIGITAL_TIMEOUTS(tmo), .PULL_UP_ENABLES(pue),
    .PULL_DIRECTION(pdir), .DUTY_ENABLE(den), .DUTY_PRESET_ZERO(10'h155),
    .DUTY_PRESET_ONE(10'h0AA), .ANALOG_PASS_TIMEOUT(8'h02),
    .LEVEL_WRITE(lw), .LEVEL_VALUES(lv), .SLEEP_SELECT(ssel),
    .SLEEP_ACTIVE(sact), .PERIPH_NORMAL(4'hF), .SPI_NORMAL(4'h5),
    .LINE_OUT(lo), .LINE_OE_N(loe), .LINE_PULL_EN(lpe), .LINE_PULL_UP(lpu),
    .DUTY_OUTPUT_ZERO(d0), .DUTY_OUTPUT_ONE(d1), .PERIPH_OUT(po),
    .SPI_OUT(so), .FRAME_EMIT(fe), .CHANGE_SAMPLE_REQ(csr));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  // Compares a settled output; all design values are zero-extended.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic level(input logic [7:0] v);
    @(posedge clk_sys);
    lw <= 1'b1;
    lv <= v;
    @(posedge clk_sys);
    lw <= 1'b0;
    lv <= ~v;
    #1;
  endtask : level

  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Commanded levels persist; a repeat with no change asks for no sample.
  task automatic t_level();
    level(8'hA0);
    chk("line_out", 16'h00A0, lo);
    chk("change_req", 16'h1, csr);
    level(8'hA0);
    chk("change_req", 16'h0, csr);
    cyc(20);
    chk("line_out", 16'h00A0, lo);
  endtask : t_level

  // Line 2 reverts after its own timeout; line 0 has none and holds.
  task automatic t_digital();
    rn.send(SRC, 16'hF005, 16'hFFFF, 8'h00, '0, '0);
    chk("line_out", 16'h00A5, lo);
    chk("frame", 16'h1, fe);
    cyc(3);
    chk("line_out", 16'h00A5, lo);
    cyc(12);
    chk("line_out", 16'h00A1, lo);
  endtask : t_digital

  // Foreign source, withheld frame, broadcast filter, transparent mode.
  task automatic t_filter();
    @(posedge clk_sys);
    fwd <= 1'b0;
    rn.send(16'h4321, 16'h0002, 16'h0002, 8'h00, '0, '0);
    chk("line_out", 16'h00A1, lo);
    chk("frame", 16'h1, fe);
    rn.send(SRC, 16'h0002, 16'h0002, 8'h00, '0, '0);
    chk("line_out", 16'h00A3, lo);
    chk("frame", 16'h0, fe);
    @(posedge clk_sys);
    filt <= 16'hFFFF;
    api  <= 1'b0;
    fwd  <= 1'b1;
    rn.send(16'h4321, 16'h0008, 16'h0008, 8'h00, '0, '0);
    chk("line_out", 16'h00AB, lo);
    chk("frame", 16'h0, fe);
    @(posedge clk_sys);
    api <= 1'b1;
  endtask : t_filter

  // Both channels pass, then the shared timeout restores both presets.
  task automatic t_analog();
    rn.send(SRC, 16'h0000, 16'h0000, 8'h03, 10'h3D0, 10'h124);
    chk("duty0", 16'h03D0, d0);
    chk("duty1", 16'h0124, d1);
    cyc(12);
    chk("duty0", 16'h0155, d0);
    chk("duty1", 16'h00AA, d1);
  endtask : t_analog

  // Sleep with a passed line and a passed duty output, then wake.
  task automatic t_sleep();
    rn.send(SRC, 16'h0004, 16'h0004, 8'h01, 10'h2AA, 10'h000);
    @(posedge clk_sys);
    sact <= 1'b1;
    cyc(1);
    chk("spi_out", 16'h5, so);
    @(posedge clk_sys);
    ssel <= 3'h1;
    cyc(1);
    chk("duty0", 16'h0, d0);
    chk("spi_out", 16'hF, so);
    chk("periph_out", 16'h1, po);
    chk("line_oe_n", 16'h1000, loe);
    chk("pull_en", 16'h1000, lpe);
    chk("pull_up", 16'h0F0F, lpu);
    cyc(30);
    chk("line_out", 16'h00AF, lo);
    @(posedge clk_sys);
    sact <= 1'b0;
    den <= 2'h1;
    cyc(1);
    chk("duty0", 16'h0155, d0);
    chk("duty1", 16'h0, d1);
    chk("periph_out", 16'hF, po);
    cyc(12);
    chk("line_out", 16'h00AB, lo);
  endtask : t_sleep

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk("line_oe_n", 16'h1FFF, loe);
    chk("line_out", 16'h0000, lo);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(3);
    t_level();
    t_digital();
    t_filter();
    t_analog();
    t_sleep();
    test_done();
  end

  // The scenarios need well under a thousand cycles.
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule : ilp_pass_tb

// File: ilp_pkg.sv
package ilp_pkg;
  `include "ilp_params.svh"

  // --------------------------------------------------------------------------
  // Shared types
  // --------------------------------------------------------------------------
  typedef logic [`ILP_DUTY_W-1:0] ilp_duty_t;

  typedef struct packed {
    logic [`ILP_TMO_W-1:0] cnt;
    logic                  active;
    logic                  expire;
  } ilp_tmr_t;

  typedef struct packed {
    logic [1:0] pipe;
  } ilp_rst_t;

  typedef struct packed {
    logic [`ILP_TICK_W-1:0]     tick_cnt;
    logic                       tick;
    logic                       asleep_d;
    logic [`ILP_NUM_LINES-1:0]  pass_act;
    logic [`ILP_NUM_LINES-1:0]  pass_lvl;
    logic [`ILP_NUM_LINES-1:0]  line_lvl;
    logic [`ILP_NUM_LINES-1:0]  line_oe_n;
    logic [`ILP_NUM_LINES-1:0]  pull_en;
    logic [`ILP_NUM_LINES-1:0]  pull_up;
    logic [`ILP_NUM_DIRECT-1:0] ovr_act;
    logic [`ILP_NUM_DIRECT-1:0] ovr_lvl;
    ilp_duty_t                  duty0_val;
    ilp_duty_t                  duty1_val;
    ilp_duty_t                  duty0_out;
    ilp_duty_t                  duty1_out;
    logic [1:0]                 duty_pass;
    logic                       frame_emit;
    logic                       change_req;
    logic [`ILP_PERIPH_W-1:0]   periph;
    logic [`ILP_SPI_W-1:0]      spi;
  } ilp_state_t;
endpackage : ilp_pkg

// File: ilp_remote_node.sv
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_remote_node (
  // Clock.
  input  wire logic                     clk,
  // Sample transaction towards the receiver.
  output logic                          valid,
  output logic [`ILP_ADDR_W-1:0]        source,
  output logic [`ILP_MASK_W-1:0]        dmask,
  output logic [`ILP_MASK_W-1:0]        ddata,
  output logic [`ILP_AMASK_W-1:0]       amask,
  output ilp_pkg::ilp_duty_t            a0,
  output ilp_pkg::ilp_duty_t            a1
);
  import ilp_pkg::*;

  initial begin
    valid  = 1'b0;
    source = '0;
    dmask  = '0;
    ddata  = '0;
    amask  = '0;
    a0     = '0;
    a1     = '0;
  end

  // One strobed sample; fields are inverted afterwards so a stale
  // value can never pass for a fresh one.
  task automatic send(input logic [15:0] s, input logic [15:0] m,
                      input logic [15:0] d, input logic [7:0] am,
                      input ilp_duty_t v0, input ilp_duty_t v1);
    @(posedge clk);
    valid  <= 1'b1;
    source <= s;
    dmask  <= m;
    ddata  <= d;
    amask  <= am;
    a0     <= v0;
    a1     <= v1;
    @(posedge clk);
    valid  <= 1'b0;
    source <= ~s;
    dmask  <= ~m;
    ddata  <= ~d;
    amask  <= ~am;
    a0     <= ~v0;
    a1     <= ~v1;
    #1;
  endtask : send
endmodule : ilp_remote_node

// File: ilp_rst_sync.sv
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_rst_sync (
  // Clock and raw reset.
  input  wire logic clk,
  input  wire logic rst_in_n,
  // Released reset.
  output logic      rst_out_n
);
  import ilp_pkg::*;

  ilp_rst_t s;
  ilp_rst_t n;

  // Shift ones in after release so the deassertion is clean on the clock.
  always_comb begin
    n      = s;
    n.pipe = {s.pipe[0], 1'b1};
  end

  // Assertion is immediate; only the release waits two edges.
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rst_out_n = s.pipe[1];
endmodule : ilp_rst_sync

// File: ilp_timeout.sv
`timescale 1ns/10ps
`include "ilp_params.svh"

module ilp_timeout (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Control.
  input  wire logic                  start,
  input  wire logic [`ILP_TMO_W-1:0] setting,
  input  wire logic                  tick,
  // Result.
  output logic                       expire
);
  import ilp_pkg::*;

  ilp_tmr_t s;
  ilp_tmr_t n;

  // A restart wins over a tick in the same cycle, so a fresh sample always
  // gets its full hold time. A zero setting never arms the timer.
  always_comb begin
    n        = s;
    n.expire = 1'b0;
    if (start) begin
      n.cnt    = setting;
      n.active = (setting != '0);
    end else if (s.active && tick) begin
      n.cnt = s.cnt - 1'b1;
      if (s.cnt == `ILP_TMO_W'(1)) begin
        n.active = 1'b0;
        n.expire = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign expire = s.expire;
endmodule : ilp_timeout
